// [rtl/ecr_router.sv]
// Eight event channels with source selection, filtering, quadrature
// decoding on channels 0, 2 and 4, and software event injection.
// Assumes sources are synchronous to mclk_i; registers over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module ecr_router
#(
   parameter logic [6:0] PRESENT = ecr_pkg::ECR_PRESENT_ALL
)
(
   input  wire logic                     mclk_i,          // Clock
   input  wire logic                     arst_n_i,        // Reset, low
   input  wire ecr_pkg::ecr_src_type     src_i,           // Event sources
   output ecr_pkg::ecr_evt_type [7:0]    chan_o,          // Channels
   input  wire logic [7:0]               s_axi_awaddr_i,  // Write addr
   input  wire logic                     s_axi_awvalid_i, // Addr valid
   output logic                          s_axi_awready_o, // Addr ready
   input  wire logic [31:0]              s_axi_wdata_i,   // Write data
   input  wire logic [3:0]               s_axi_wstrb_i,   // Byte strobes
   input  wire logic                     s_axi_wvalid_i,  // Data valid
   output logic                          s_axi_wready_o,  // Data ready
   output logic [1:0]                    s_axi_bresp_o,   // Write resp
   output logic                          s_axi_bvalid_o,  // Resp valid
   input  wire logic                     s_axi_bready_i,  // Resp ready
   input  wire logic [7:0]               s_axi_araddr_i,  // Read addr
   input  wire logic                     s_axi_arvalid_i, // Addr valid
   output logic                          s_axi_arready_o, // Addr ready
   output logic [31:0]                   s_axi_rdata_o,   // Read data
   output logic [1:0]                    s_axi_rresp_o,   // Read resp
   output logic                          s_axi_rvalid_o,  // Data valid
   input  wire logic                     s_axi_rready_i   // Data ready
);
   import ecr_pkg::*;

   // Register file
   logic [7:0]        src_sel_reg [ECR_CH_N];
   logic [7:0]        ctrl_reg    [ECR_CH_N];
   logic [7:0]        trig_reg;
   logic [7:0]        value_reg;

   // Event path
   ecr_src_type       src_reg;
   logic [ECR_PRESC_W-1:0] presc_reg;
   logic [15:0]       tick_w;
   logic [7:0]        raw_w;
   logic [7:0]        lvl_w;
   ecr_evt_type [7:0] routed_w;
   ecr_evt_type [7:0] evt_reg;
   logic [7:0]        inj_w;

   // Bus slave state
   logic              aw_hold_reg;
   logic              w_hold_reg;
   logic [7:0]        aw_addr_reg;
   logic [7:0]        w_data_reg;
   logic              w_strb_reg;
   logic              awready_reg;
   logic              wready_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        rresp_reg;
   logic [31:0]       rd_word_w;
   logic              rd_ok_w;

   // Selects one registered source; absent or reserved codes read zero
   function automatic logic ecr_pick(input logic [7:0] sel,
      input ecr_src_type s, input logic [15:0] tk);
      logic [3:0] hi;
      logic [3:0] lo;
      logic       r;
      hi = sel[7:4];
      lo = sel[3:0];
      r  = 1'b0;
      case (hi)
         ECR_GRP_NONE:
            if (PRESENT[ECR_HAS_RTC])
               r = (lo == ECR_LO_RTC_OVF) ? s.rtc_ovf
                 : (lo == ECR_LO_RTC_CMP) ? s.rtc_cmp : 1'b0;
         ECR_GRP_AC:
            if (lo <= ECR_LO_AC_LAST)
               r = s.comparator[lo[2:0]]
                 & ((lo[2:0] < ECR_AC_B_FIRST) ? PRESENT[ECR_HAS_AC_A]
                                               : PRESENT[ECR_HAS_AC_B]);
         ECR_GRP_ADC:
            if (!lo[3])
               r = s.converter[lo[2:0]]
                 & (lo[2] ? PRESENT[ECR_HAS_ADC_B] : PRESENT[ECR_HAS_ADC_A]);
         ECR_GRP_PORT0, ECR_GRP_PORT1, ECR_GRP_PORT2:
            r = s.port_pin[{hi[1:0] - 2'h1, lo}]
              & PRESENT[ECR_HAS_PORT];
         ECR_GRP_PRESC:
            r = tk[lo];
         ECR_GRP_TC0, ECR_GRP_TC1, ECR_GRP_TC2, ECR_GRP_TC3:
            if (lo[2:0] != ECR_TC_RSVD_LO && lo[2:0] != ECR_TC_RSVD_HI)
               r = s.timer_evt[{hi[1:0], lo}] & PRESENT[ECR_HAS_TC];
         default:
            r = 1'b0;
      endcase
      return r;
   endfunction

   // Forward when phase B leads phase A: {a,b} 00,01,11,10
   function automatic logic ecr_fwd(input logic [1:0] p, input logic [1:0] c);
      return (p == 2'h0 && c == 2'h1) || (p == 2'h1 && c == 2'h3)
          || (p == 2'h3 && c == 2'h2) || (p == 2'h2 && c == 2'h0);
   endfunction

   // Prescaler: tap m pulses once every 2^m clocks
   genvar m;
   generate
      for (m = 0; m < 16; m++)
      begin : g_tick
         if (m == 0)
         begin : g_one
            assign tick_w[m] = 1'b1;
         end
         else
         begin : g_div
            assign tick_w[m] = &presc_reg[m-1:0];
         end
      end
   endgenerate

   // Bus decoding
   wire       aw_take_w = s_axi_awvalid_i & awready_reg;
   wire       w_take_w  = s_axi_wvalid_i & wready_reg;
   wire       ar_take_w = s_axi_arvalid_i & arready_reg;
   wire       wr_go_w   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   wire [5:0] wr_idx_w  = aw_addr_reg[7:2];
   wire       wr_en_w   = wr_go_w & w_strb_reg;
   wire       wr_map_w  = (wr_idx_w < ECR_IDX_TRIG)
                        || (wr_idx_w == ECR_IDX_TRIG)
                        || (wr_idx_w == ECR_IDX_VALUE)
                        || (wr_idx_w == ECR_IDX_STATUS);
   wire       trig_go_w = wr_en_w & (wr_idx_w == ECR_IDX_TRIG);

   wire aw_hold_next = (aw_hold_reg & ~wr_go_w) | aw_take_w;
   wire w_hold_next  = (w_hold_reg & ~wr_go_w) | w_take_w;
   wire bvalid_next  = (bvalid_reg & ~s_axi_bready_i) | wr_go_w;
   wire rvalid_next  = (rvalid_reg & ~s_axi_rready_i) | ar_take_w;

   // Channels
   genvar k;
   generate
      for (k = 0; k < ECR_CH_N; k++)
      begin : g_ch
         assign raw_w[k] = ecr_pick(src_sel_reg[k], src_reg, tick_w);

         ecr_filter u_filt
         (
            .mclk_i   (mclk_i),
            .arst_n_i (arst_n_i),
            .sample_i (raw_w[k]),
            .code_i   (ctrl_reg[k][ECR_FILT_LSB +: 3]),
            .level_o  (lvl_w[k])
         );

         // channel carries pairs; either bit nonzero
         assign inj_w[k] = trig_go_w & (w_data_reg[k] | value_reg[k]);

         // decoder only on channels 0, 2, 4
         if (k % 2 == 0 && k < 6)
         begin : g_qd
            logic       phb_w;
            logic [1:0] st_reg;
            logic [1:0] st_w;
            logic       step_w;
            logic       idx_w;
            wire        qd_en  = ctrl_reg[k][ECR_QD_EN_BIT];
            wire        idx_en = ctrl_reg[k][ECR_IDX_EN_BIT];

            // Phase B is the next pin after the selected phase A pin
            ecr_filter u_phb
            (
               .mclk_i   (mclk_i),
               .arst_n_i (arst_n_i),
               .sample_i (ecr_pick(src_sel_reg[k] + 8'h01, src_reg, tick_w)),
               .code_i   (ctrl_reg[k][ECR_FILT_LSB +: 3]),
               .level_o  (phb_w)
            );

            assign st_w   = {lvl_w[k], phb_w};
            assign step_w = ^(st_w ^ st_reg);
            // index from next channel, state match
            assign idx_w  = idx_en & lvl_w[k+1]
                          & (st_w == ctrl_reg[k][ECR_MATCH_LSB +: 2]);

            always_comb
            begin
               if (!qd_en)
                  routed_w[k] = '{strb: lvl_w[k], data: 1'b0};
               else if (idx_w)
                  routed_w[k] = '{strb: 1'b0, data: 1'b1};
               else if (step_w)
                  routed_w[k] = '{strb: 1'b1, data: ecr_fwd(st_reg, st_w)};
               else
                  routed_w[k] = '{strb: 1'b0, data: 1'b0};
            end

            always_ff @(posedge mclk_i or negedge arst_n_i)
            begin
               if (!arst_n_i)
                  st_reg <= 2'h0;
               else
                  st_reg <= st_w;
            end
         end
         else
         begin : g_plain
            assign routed_w[k] = '{strb: lvl_w[k], data: 1'b0};
         end

         always_ff @(posedge mclk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
            begin
               src_sel_reg[k] <= ECR_REG_RESET;
               ctrl_reg[k]    <= ECR_REG_RESET;
               evt_reg[k]     <= '{strb: 1'b0, data: 1'b0};
            end
            else
            begin
               if (wr_en_w && wr_idx_w == ECR_IDX_SRC_SEL0 + 6'(k))
                  src_sel_reg[k] <= w_data_reg;
               if (wr_en_w && wr_idx_w == ECR_IDX_CTRL0 + 6'(k))
                  ctrl_reg[k] <= w_data_reg & ((k % 2 == 0 && k < 6)
                                 ? ECR_CTRL_MASK_QD : ECR_CTRL_MASK_PLAIN);
               if (inj_w[k])
                  evt_reg[k] <= '{strb: w_data_reg[k], data: value_reg[k]};
               else
                  evt_reg[k] <= routed_w[k];
            end
         end
      end
   endgenerate

   // Read decode; unmapped indexes answer with an error and zero data
   always_comb
   begin
      rd_word_w = 32'h0000_0000;
      rd_ok_w   = 1'b1;
      if (s_axi_araddr_i[7:2] < ECR_IDX_CTRL0)
         rd_word_w[7:0] = src_sel_reg[s_axi_araddr_i[4:2]];
      else if (s_axi_araddr_i[7:2] < ECR_IDX_TRIG)
         rd_word_w[7:0] = ctrl_reg[s_axi_araddr_i[4:2]];
      else if (s_axi_araddr_i[7:2] == ECR_IDX_TRIG)
         rd_word_w[7:0] = trig_reg;
      else if (s_axi_araddr_i[7:2] == ECR_IDX_VALUE)
         rd_word_w[7:0] = value_reg;
      else if (s_axi_araddr_i[7:2] == ECR_IDX_STATUS)
      begin
         for (int i = 0; i < ECR_CH_N; i++)
         begin
            rd_word_w[i]     = evt_reg[i].strb;
            rd_word_w[i + 8] = evt_reg[i].data;
         end
      end
      else
         rd_ok_w = 1'b0;
   end

   // first stage: sources registered, prescaler free-running
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         src_reg   <= '0;
         presc_reg <= '0;
      end
      else
      begin
         src_reg   <= src_i;
         presc_reg <= presc_reg + 15'h0001;
      end
   end

   // Software registers; the value must already hold when trigger lands
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         trig_reg  <= ECR_REG_RESET;
         value_reg <= ECR_REG_RESET;
      end
      else
      begin
         if (trig_go_w)
            trig_reg <= w_data_reg;
         if (wr_en_w && wr_idx_w == ECR_IDX_VALUE)
            value_reg <= w_data_reg;
      end
   end

   // Write channels: address and data held apart, written together
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= ECR_RESP_OKAY;
      end
      else
      begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg  <= w_hold_next;
         if (aw_take_w)
            aw_addr_reg <= s_axi_awaddr_i;
         if (w_take_w)
         begin
            w_data_reg <= s_axi_wdata_i[7:0];
            w_strb_reg <= s_axi_wstrb_i[0];
         end
         awready_reg <= ~aw_hold_next & ~bvalid_next;
         wready_reg  <= ~w_hold_next & ~bvalid_next;
         bvalid_reg  <= bvalid_next;
         if (wr_go_w)
            bresp_reg <= wr_map_w ? ECR_RESP_OKAY : ECR_RESP_SLVERR;
      end
   end

   // Read channel: one read in flight, data captured at the address
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= ECR_RESP_OKAY;
      end
      else
      begin
         arready_reg <= ~rvalid_next;
         rvalid_reg  <= rvalid_next;
         if (ar_take_w)
         begin
            rdata_reg <= rd_word_w;
            rresp_reg <= rd_ok_w ? ECR_RESP_OKAY : ECR_RESP_SLVERR;
         end
      end
   end

   assign chan_o          = evt_reg;
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign s_axi_rresp_o   = rresp_reg;

endmodule

`default_nettype wire

// [inc/ecr_pkg.sv]
// Constants, register map and carrier types for the event channel router.
// Assumes one peripheral clock and an AXI4-Lite master on the register side.

package ecr_pkg;

   localparam int ECR_CH_N    = 8;
   localparam int ECR_ADDR_W  = 8;
   localparam int ECR_IDX_W   = 6;

   // Register indexes; byte address is four times the index
   localparam logic [5:0] ECR_IDX_SRC_SEL0 = 6'h00;
   localparam logic [5:0] ECR_IDX_CTRL0    = 6'h08;
   localparam logic [5:0] ECR_IDX_TRIG     = 6'h10;
   localparam logic [5:0] ECR_IDX_VALUE    = 6'h11;
   localparam logic [5:0] ECR_IDX_STATUS   = 6'h18;

   // Channel control field positions and write masks
   localparam int ECR_MATCH_LSB  = 5;
   localparam int ECR_IDX_EN_BIT = 4;
   localparam int ECR_QD_EN_BIT  = 3;
   localparam int ECR_FILT_LSB   = 0;
   localparam logic [7:0] ECR_CTRL_MASK_QD    = 8'h7f;
   localparam logic [7:0] ECR_CTRL_MASK_PLAIN = 8'h07;
   localparam logic [7:0] ECR_REG_RESET       = 8'h00;

   // Selector groups (upper nibble) and codes (lower nibble)
   localparam logic [3:0] ECR_GRP_NONE  = 4'h0;
   localparam logic [3:0] ECR_GRP_AC    = 4'h1;
   localparam logic [3:0] ECR_GRP_ADC   = 4'h2;
   localparam logic [3:0] ECR_GRP_PORT0 = 4'h5;
   localparam logic [3:0] ECR_GRP_PORT1 = 4'h6;
   localparam logic [3:0] ECR_GRP_PORT2 = 4'h7;
   localparam logic [3:0] ECR_GRP_PRESC = 4'h8;
   localparam logic [3:0] ECR_GRP_TC0   = 4'hc;
   localparam logic [3:0] ECR_GRP_TC1   = 4'hd;
   localparam logic [3:0] ECR_GRP_TC2   = 4'he;
   localparam logic [3:0] ECR_GRP_TC3   = 4'hf;
   localparam logic [3:0] ECR_LO_RTC_OVF = 4'h8;
   localparam logic [3:0] ECR_LO_RTC_CMP = 4'h9;
   localparam logic [3:0] ECR_LO_AC_LAST = 4'h5;
   localparam logic [2:0] ECR_AC_B_FIRST = 3'h3;
   localparam logic [2:0] ECR_TC_RSVD_LO = 3'h2;
   localparam logic [2:0] ECR_TC_RSVD_HI = 3'h3;
   localparam int ECR_PRESC_W = 15;

   // Presence bits of the peripheral groups
   localparam int ECR_HAS_RTC   = 0;
   localparam int ECR_HAS_AC_A  = 1;
   localparam int ECR_HAS_AC_B  = 2;
   localparam int ECR_HAS_ADC_A = 3;
   localparam int ECR_HAS_ADC_B = 4;
   localparam int ECR_HAS_PORT  = 5;
   localparam int ECR_HAS_TC    = 6;
   localparam logic [6:0] ECR_PRESENT_ALL = 7'h7f;

   localparam logic [1:0] ECR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] ECR_RESP_SLVERR = 2'h2;

   // Event sources; comparator[2:0] is A ch0/ch1/window, [5:3] is B.
   // converter[3:0] is converter A, [7:4] converter B.
   // port_pin index is port*16+pin; timer_evt index is timer*16+type.
   typedef struct packed {
      logic        rtc_ovf;
      logic        rtc_cmp;
      logic [5:0]  comparator;
      logic [7:0]  converter;
      logic [47:0] port_pin;
      logic [63:0] timer_evt;
   } ecr_src_type;

   // One channel as seen by users: strb is the signaling part
   typedef struct packed {
      logic strb;
      logic data;
   } ecr_evt_type;

endpackage

// [rtl/ecr_filter.sv]
// Sample-count glitch filter for one routed event source.
// Assumes the sample is already registered on mclk_i.
`timescale 1ns/10ps
`default_nettype none

module ecr_filter
(
   input  wire logic       mclk_i,    // Peripheral clock
   input  wire logic       arst_n_i,  // Async reset, active low
   input  wire logic       sample_i,  // Selected source level
   input  wire logic [2:0] code_i,    // Samples needed minus one
   output logic            level_o    // Filtered level
);
   import ecr_pkg::*;

   logic       prev_reg;
   logic [2:0] run_reg;
   logic [2:0] run_next;
   wire        same_w;

   assign same_w   = (sample_i == prev_reg);
   // Saturates at eight equal samples, the longest the code allows
   assign run_next = !same_w ? 3'h0
                   : (run_reg == 3'h7) ? 3'h7 : run_reg + 3'h1;
   assign level_o  = sample_i & (run_next >= code_i);

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         prev_reg <= 1'b0;
         run_reg  <= 3'h0;
      end
      else
      begin
         prev_reg <= sample_i;
         run_reg  <= run_next;
      end
   end

endmodule

`default_nettype wire

// [dv/ecr_src_model.sv]
// Peripheral event sources seen by the router.
// Assumes the bench requests events just after a clock edge.
`timescale 1ns/10ps
`default_nettype none

module ecr_src_model
(
   input  wire logic           mclk_i,   // Clock
   input  wire logic           arst_n_i, // Reset, low
   input  wire logic [127:0]   pulse_i,  // One-cycle events
   input  wire logic [127:0]   level_i,  // Held levels
   output var ecr_pkg::ecr_src_type src_o // Source bundle
);
   import ecr_pkg::*;
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         src_o <= ecr_src_type'(128'h0);
      else
         src_o <= ecr_src_type'(pulse_i | level_i);
   end
endmodule

`default_nettype wire

// [dv/ecr_router_assertions.sv]
// Port checks for the event router.
// Bound into ecr_router; sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module ecr_router_assertions
(
   input wire logic        mclk_i,          // Clock
   input wire logic        arst_n_i,        // Reset
   input wire ecr_pkg::ecr_src_type src_i,  // Sources
   input wire ecr_pkg::ecr_evt_type [7:0] chan_o, // Channels
   input wire logic [7:0]  s_axi_awaddr_i,  // AW addr
   input wire logic        s_axi_awvalid_i, // AW valid
   input wire logic        s_axi_awready_o, // AW ready
   input wire logic [31:0] s_axi_wdata_i,   // W data
   input wire logic [3:0]  s_axi_wstrb_i,   // W strobes
   input wire logic        s_axi_wvalid_i,  // W valid
   input wire logic        s_axi_wready_o,  // W ready
   input wire logic [1:0]  s_axi_bresp_o,   // B resp
   input wire logic        s_axi_bvalid_o,  // B valid
   input wire logic        s_axi_bready_i,  // B ready
   input wire logic [7:0]  s_axi_araddr_i,  // AR addr
   input wire logic        s_axi_arvalid_i, // AR valid
   input wire logic        s_axi_arready_o, // AR ready
   input wire logic [31:0] s_axi_rdata_o,   // R data
   input wire logic [1:0]  s_axi_rresp_o,   // R resp
   input wire logic        s_axi_rvalid_o,  // R valid
   input wire logic        s_axi_rready_i   // R ready
);
   import ecr_pkg::*;
   logic [7:0] trig_reg;
   logic [5:0] ar_idx_reg;
   logic [7:0] strb_w;
   wire logic  aw_hit = s_axi_awvalid_i & s_axi_awready_o;
   wire logic  w_hit = s_axi_wvalid_i & s_axi_wready_o;
   wire logic  trig_wr = aw_hit & w_hit & s_axi_wstrb_i[0]
                         & (s_axi_awaddr_i == {ECR_IDX_TRIG, 2'b00});
   wire logic  ctrl_rd = (ar_idx_reg[5:3] == 3'h1);
   // Only channels 0, 2 and 4 keep the decoder fields
   wire logic [7:0] ctrl_mask = (!ar_idx_reg[0] && ar_idx_reg[2:1] != 2'h3)
                                ? ECR_CTRL_MASK_QD : ECR_CTRL_MASK_PLAIN;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         strb_w[i] = chan_o[i].strb;
   end
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         trig_reg <= 8'h00;
      else if (trig_wr)
         trig_reg <= s_axi_wdata_i[7:0];
   end
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         ar_idx_reg <= 6'h00;
      else if (s_axi_arvalid_i & s_axi_arready_o)
         ar_idx_reg <= s_axi_araddr_i[7:2];
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   a_bresp_hold: assert property (
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
      && $stable(s_axi_bresp_o)) else $error("write response dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o)) else $error("read data dropped");
   a_ar_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken during read answer");
   a_aw_refuse: assert property (
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken during write answer");
   a_read_answer: assert property (
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_write_answer: assert property (aw_hit && w_hit |-> ##2 s_axi_bvalid_o)
      else $error("write answer late");
   a_inject_seen: assert property (
      trig_wr |-> ##[1:4] ((strb_w & trig_reg) == trig_reg))
      else $error("injected strobe missing");
   a_ctrl_mask: assert property (
      s_axi_rvalid_o && ctrl_rd |-> (s_axi_rdata_o[7:0] & ~ctrl_mask) == 8'h00)
      else $error("control field reads nonzero");
endmodule

bind ecr_router ecr_router_assertions i_ecr_router_assertions (
   .mclk_i(mclk_i), .arst_n_i(arst_n_i), .src_i(src_i), .chan_o(chan_o),
   .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
   .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i));

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the event router.
// Sources come from ecr_src_model; registers via AXI4-Lite tasks.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import ecr_pkg::*;
   logic mclk = 1'b0, arst_n = 1'b0;
   logic [127:0] pulse = 128'h0, level = 128'h0;
   ecr_src_type src;
   ecr_evt_type [7:0] chan;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [15:0] exp_q[$];
   int error_cnt = 0, compares = 0, guard = 0;
   logic [7:0] rsv[10] = '{8'h00, 8'h01, 8'h0a, 8'h16, 8'h18, 8'h28,
                           8'h30, 8'h40, 8'h90, 8'hc2};
   logic [1:0] qd[8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
   logic [7:0] sbase[5] = '{8'h08, 8'h10, 8'h20, 8'h50, 8'hc0};
   int bbase[5] = '{127, 120, 112, 64, 0};
   int lim[5] = '{2, 6, 8, 48, 64};

   always #12.5 mclk = ~mclk;

   ecr_src_model i_ecr_src_model (.mclk_i(mclk), .arst_n_i(arst_n),
      .pulse_i(pulse), .level_i(level), .src_o(src));
   ecr_router i_ecr_router (.mclk_i(mclk), .arst_n_i(arst_n), .src_i(src),
      .chan_o(chan), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready));

   task automatic test_done;
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      compares++;
      if (got !== ex)
      begin
         $display("ERROR %s expected %h seen %h", nm, ex, got);
         error_cnt++;
      end
   endtask

   // One global bound keeps every wait finite
   task automatic tick;
      @(posedge mclk);
      guard++;
      if (guard > 40000)
      begin
         chk("timeout", 32'h0, 32'(guard));
         test_done;
      end
   endtask

   task automatic wr(input logic [5:0] ix, input logic [7:0] d,
                     input logic [1:0] er = ECR_RESP_OKAY);
      logic a_done, w_done;
      a_done = 1'b0;
      w_done = 1'b0;
      awaddr <= {ix, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a_done && w_done))
      begin
         tick;
         if (awready)
         begin
            awvalid <= 1'b0;
            a_done = 1'b1;
         end
         if (wready)
         begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      while (!bvalid)
         tick;
      bready <= 1'b1;
      tick;
      chk("bresp", 32'(er), 32'(bresp));
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] ix, input logic [7:0] ex,
                     input logic [1:0] er = ECR_RESP_OKAY);
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      do
         tick;
      while (!arready);
      arvalid <= 1'b0;
      while (!rvalid)
         tick;
      rready <= 1'b1;
      tick;
      chk("rdata", {24'h0, ex}, rdata);
      chk("rresp", 32'(er), 32'(rresp));
      rready <= 1'b0;
   endtask

   task automatic fire(input logic [127:0] m);
      pulse <= m;
      tick;
      pulse <= 128'h0;
      repeat (12)
         tick;
   endtask

   task automatic route_one;
      int c, k, n, b;
      c = $urandom % 8;
      k = $urandom % 5;
      n = $urandom % lim[k];
      if (k == 4 && n % 8 inside {2, 3})
         n = n + 2;
      b = (k == 0) ? 127 - n : bbase[k] + n;
      wr(ECR_IDX_SRC_SEL0 + 6'(c), sbase[k] + 8'(n));
      exp_q.push_back(16'h2 << (2 * c));
      fire(128'h1 << b);
      wr(ECR_IDX_SRC_SEL0 + 6'(c), 8'h00);
   endtask

   always @(posedge mclk)
   begin
      if (arst_n && chan !== 16'h0)
      begin
         if (exp_q.size() == 0)
            chk("chan", 32'h0, 32'(chan));
         else
            chk("chan", 32'(exp_q.pop_front()), 32'(chan));
      end
   end

   initial
   begin
      logic [7:0] t, v;
      logic [15:0] e;
      void'($urandom(76));
      repeat (5)
         @(posedge mclk);
      arst_n <= 1'b1;
      tick;
      for (int i = 0; i < 8; i++)
      begin
         rd(6'(i), ECR_REG_RESET);
         rd(ECR_IDX_CTRL0 + 6'(i), ECR_REG_RESET);
         wr(ECR_IDX_CTRL0 + 6'(i), 8'h7f);
         rd(ECR_IDX_CTRL0 + 6'(i), (i % 2 == 0 && i < 6) ?
            ECR_CTRL_MASK_QD : ECR_CTRL_MASK_PLAIN);
         wr(ECR_IDX_CTRL0 + 6'(i), 8'h00);
      end
      rd(6'h20, 8'h00, ECR_RESP_SLVERR);
      wr(6'h20, 8'h55, ECR_RESP_SLVERR);
      foreach (rsv[k])
      begin
         wr(ECR_IDX_SRC_SEL0 + 6'h1, rsv[k]);
         fire(~128'h0);
      end
      wr(ECR_IDX_SRC_SEL0 + 6'h1, 8'h00);
      repeat (30)
         route_one;
      repeat (2)
         exp_q.push_back(16'h0002);
      wr(ECR_IDX_SRC_SEL0, 8'h81);
      wr(ECR_IDX_SRC_SEL0, 8'h00);
      wr(ECR_IDX_SRC_SEL0 + 6'h3, 8'h50);
      wr(ECR_IDX_CTRL0 + 6'h3, 8'h03);
      for (int n = 3; n < 5; n++)
      begin
         if (n == 4)
            exp_q.push_back(16'h0080);
         level[64] <= 1'b1;
         repeat (n)
            tick;
         level[64] <= 1'b0;
         repeat (12)
            tick;
      end
      wr(ECR_IDX_SRC_SEL0 + 6'h3, 8'h00);
      wr(ECR_IDX_SRC_SEL0, 8'h50);
      wr(ECR_IDX_CTRL0, 8'h08);
      foreach (qd[k])
      begin
         exp_q.push_back(k < 4 ? 16'h0003 : 16'h0002);
         // Phase A on pin 0, phase B on pin 1
         level[65:64] <= {qd[k][0], qd[k][1]};
         repeat (8)
            tick;
      end
      wr(ECR_IDX_CTRL0, 8'h18);
      wr(ECR_IDX_SRC_SEL0 + 6'h1, 8'h52);
      exp_q.push_back(16'h0009);
      fire(128'h1 << 66);
      wr(ECR_IDX_CTRL0, 8'h00);
      wr(ECR_IDX_SRC_SEL0, 8'h00);
      repeat (4)
      begin
         v = 8'($urandom);
         t = 8'($urandom) | 8'h01;
         for (int n = 0; n < 8; n++)
            e[2 * n +: 2] = {t[n], v[n]};
         wr(ECR_IDX_VALUE, v);
         exp_q.push_back(e);
         wr(ECR_IDX_TRIG, t);
         repeat (6)
            tick;
      end
      repeat (12)
         tick;
      chk("pending", 32'h0, 32'(exp_q.size()));
      test_done;
   end
endmodule

`default_nettype wire
